// ### rtl/charger_fault_flag_and_event_mask.sv
`timescale 1ns/1ps
// Behaviour
// - Fault flag bit 7 is set on entry into input under-voltage and clears when read.
// - Fault flag bit 6 is set on entry into input over-voltage and clears when read.
// - Fault flag bit 5 is set on entry into battery over-current and clears when read.
// - Fault flag bit 4 is set on entry into battery over-voltage and clears when read.
// - Fault flag bit 3 is set on entry into thermal shutdown and clears when read.
// - Fault flag bit 2 is set only on the rising edge of safety timer expiry.
// - Fault flag bit 1 is set on a gate-driver supply fault; bit 0 reads zero.
// - The first mask register sits at 0x28, resets to 0x00 and register reset restores it.
// - Mask bit 7 gates the ADC done pulse, and only in one-shot mode.
// - Mask bit 6 gates the input current regulation pulse.
// - Mask bit 5 gates the input voltage regulation pulse.
// - Mask bit 3 gates the watchdog expiry pulse; bits 4 and 2 are reserved.
// - Mask bit 1 gates the rising edge of constant-voltage timer expiry.
// - Mask bit 0 gates any change of the charge state field.
// - In continuous ADC mode the ADC done flag always reads zero.
module charger_fault_flag_and_event_mask
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port.
   input wire chg_irq_pkg::reg_req_t req_i,
   output logic [7:0] rdata_o,
   // Fault and event conditions, all levels.
   input wire chg_irq_pkg::fault_in_t fault_i,
   input wire chg_irq_pkg::event_in_t event_i,
   // Interrupts.
   output logic int_pulse_o,
   output logic irq_o
);
   import chg_irq_pkg::*;

   irq_state_t st;
   irq_state_t next_st;
   logic [6:0] fault_now;
   logic [6:0] fault_rise;
   logic [4:0] ev_now;
   logic [4:0] ev_rise;
   logic [7:0] ev_set;
   logic [7:0] fault_set;
   logic rd_fault;
   logic rd_event;
   logic rd_status;
   logic wr_any;
   logic reg_reset;
   logic pulse_req;
   logic [7:0] rdata_next;

   assign fault_now = {fault_i.input_undervoltage, fault_i.input_overvoltage,
      fault_i.battery_overcurrent, fault_i.battery_overvoltage,
      fault_i.thermal_shutdown, fault_i.charge_timer_expired,
      fault_i.gate_driver_supply_pin_fault};
   assign ev_now = {event_i.adc_done, event_i.input_current_regulation,
      event_i.input_voltage_regulation, event_i.host_watchdog_expired,
      event_i.cv_timer_expired};

   always_comb
   begin
      next_st = st;
      wr_any = req_i.wr;
      rd_fault = req_i.rd && (req_i.addr == fault_flags_addr);
      rd_event = req_i.rd && (req_i.addr == event_flags_addr);
      rd_status = req_i.rd && (req_i.addr == irq_status_addr);
      reg_reset = wr_any && (req_i.addr == control_addr) && req_i.wdata[ctrl_regreset_bit];
      // Entry into each fault condition is its rising edge.
      fault_rise = fault_now & ~st.fault_prev;
      ev_rise = ev_now & ~st.event_prev;
      fault_set = {fault_rise, 1'b0};
      ev_set = 8'h00;
      ev_set[ev_adc_bit] = ev_rise[4] && st.oneshot;
      ev_set[ev_iac_bit] = ev_rise[3];
      ev_set[ev_vac_bit] = ev_rise[2];
      ev_set[ev_wd_bit] = ev_rise[1];
      ev_set[ev_cv_bit] = ev_rise[0];
      ev_set[ev_chg_bit] = (event_i.charge_state != st.charge_prev);
      next_st.fault_prev = fault_now;
      next_st.event_prev = ev_now;
      next_st.charge_prev = event_i.charge_state;
      // A read clears, but an edge in the same cycle is kept: set wins.
      next_st.fault_flags = ((rd_fault ? 8'h00 : st.fault_flags) | fault_set)
         & fault_flags_wmask;
      next_st.event_flags = (rd_event ? 8'h00 : st.event_flags) | ev_set;
      // Fault events always pulse: their masks live outside this block.
      pulse_req = (|fault_set) || (|(ev_set & ~st.masks_first));
      next_st.irq_pulse = pulse_req;
      next_st.irq_status = rd_status ? st.irq_status : st.irq_status;
      if (wr_any && req_i.addr == irq_status_addr)
      begin
         next_st.irq_status = st.irq_status & ~req_i.wdata[1:0];
      end
      next_st.irq_status[irq_fault_bit] = next_st.irq_status[irq_fault_bit] | (|fault_set);
      next_st.irq_status[irq_charger_bit] = next_st.irq_status[irq_charger_bit]
         | (|(ev_set & ~st.masks_first));
      if (wr_any && req_i.addr == irq_enable_addr)
      begin
         next_st.irq_enable = req_i.wdata[1:0];
      end
      if (wr_any && req_i.addr == masks_first_addr)
      begin
         next_st.masks_first = req_i.wdata & masks_first_wmask;
      end
      if (wr_any && req_i.addr == control_addr)
      begin
         next_st.oneshot = req_i.wdata[ctrl_oneshot_bit];
      end
      if (reg_reset)
      begin
         next_st.masks_first = masks_first_reset;
         next_st.irq_enable = 2'h0;
         next_st.oneshot = 1'b0;
      end
      // The mode of the coming cycle decides, so a switch to continuous mode drops the flag at once.
      if (!next_st.oneshot)
      begin
         next_st.event_flags[ev_adc_bit] = 1'b0;
      end
      rdata_next = reg_reset_value;
      unique case (req_i.addr)
         fault_flags_addr: rdata_next = st.fault_flags;
         event_flags_addr: rdata_next = st.event_flags;
         masks_first_addr: rdata_next = st.masks_first;
         irq_status_addr: rdata_next = {6'h00, st.irq_status};
         irq_enable_addr: rdata_next = {6'h00, st.irq_enable};
         control_addr: rdata_next = {7'h00, st.oneshot};
         default: rdata_next = 8'h00;
      endcase
      next_st.rdata = req_i.rd ? rdata_next : 8'h00;
   end

   // The reset seeds fault_prev as clear so a fault already present counts as entered.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign int_pulse_o = st.irq_pulse;
   assign irq_o = |(st.irq_status & st.irq_enable);

   a_fault_uv_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fault_i.input_undervoltage && !st.fault_prev[6] |=> st.fault_flags[fault_uv_bit])
      else $error("under-voltage flag not set");
   a_fault_ov_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fault_i.input_overvoltage && !st.fault_prev[5] |=> st.fault_flags[fault_ov_bit])
      else $error("over-voltage flag not set");
   a_fault_ocp_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(fault_i.battery_overcurrent) |=> st.fault_flags[fault_ocp_bit])
      else $error("over-current flag not set");
   a_fault_read_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_fault && fault_rise == 7'h00 |=> st.fault_flags == 8'h00)
      else $error("fault flags not cleared by read");
   a_thermal_shutdown_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(fault_i.thermal_shutdown) |=> st.fault_flags[fault_thermal_shutdown_bit])
      else $error("thermal flag not set");
   a_timer_level_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_fault && fault_i.charge_timer_expired && st.fault_prev[1]
      |=> !st.fault_flags[fault_tmr_bit])
      else $error("timer flag set without edge");
   a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      st.fault_flags[0] == 1'b0 && st.masks_first[4] == 1'b0 && st.masks_first[2] == 1'b0)
      else $error("reserved bit set");
   a_mask_read_back: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      req_i.wr && req_i.addr == masks_first_addr ##1 req_i.rd && req_i.addr == masks_first_addr
      |=> rdata_o == ($past(req_i.wdata, 2) & masks_first_wmask))
      else $error("mask read back wrong");
   a_masked_no_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fault_rise == 7'h00 && (ev_set & ~st.masks_first) == 8'h00 |=> !int_pulse_o)
      else $error("pulse while masked");
   a_flag_despite_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_rise[3] |=> st.event_flags[ev_iac_bit])
      else $error("masked event lost its flag");
   a_adc_cont_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !st.oneshot |-> !st.event_flags[ev_adc_bit])
      else $error("adc flag in continuous mode");
   a_charge_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      event_i.charge_state != st.charge_prev && !st.masks_first[ev_chg_bit] |=> int_pulse_o)
      else $error("charge change no pulse");

   a_bov_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fault_rise[3] |=> st.fault_flags[fault_bov_bit])
      else $error("battery over-voltage flag not set");
   a_timer_edge_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fault_rise[1] |=> st.fault_flags[fault_tmr_bit])
      else $error("timer flag not set on edge");
   a_drv_fault_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fault_rise[0] |=> st.fault_flags[fault_drv_bit])
      else $error("driver supply flag not set");
   a_adc_oneshot_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_rise[4] && st.oneshot && !st.masks_first[ev_adc_bit] |=> int_pulse_o)
      else $error("adc done no pulse");
   a_vac_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_rise[2] && !st.masks_first[ev_vac_bit] |=> int_pulse_o)
      else $error("voltage regulation no pulse");
   a_wd_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_rise[1] && !st.masks_first[ev_wd_bit] |=> int_pulse_o)
      else $error("watchdog expiry no pulse");
   a_cv_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_rise[0] && !st.masks_first[ev_cv_bit] |=> int_pulse_o)
      else $error("cv timer no pulse");

   c_fault_pulse: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(fault_i.input_undervoltage) ##1 int_pulse_o);
   c_masked_event: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      ev_rise[2] && st.masks_first[ev_vac_bit]);
   c_set_with_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_fault && fault_rise != 7'h00);
   c_irq_level: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));

endmodule : charger_fault_flag_and_event_mask

// ### rtl/chg_irq_pkg.sv
package chg_irq_pkg;

   // Register map, 8-bit registers at their printed byte offsets.
   localparam logic [7:0] event_flags_addr = 8'h25;
   localparam logic [7:0] fault_flags_addr = 8'h27;
   localparam logic [7:0] masks_first_addr = 8'h28;
   localparam logic [7:0] irq_status_addr = 8'h30;
   localparam logic [7:0] irq_enable_addr = 8'h31;
   localparam logic [7:0] control_addr = 8'h32;

   // Fault flag bit positions.
   localparam int fault_uv_bit = 7;
   localparam int fault_ov_bit = 6;
   localparam int fault_ocp_bit = 5;
   localparam int fault_bov_bit = 4;
   localparam int fault_thermal_shutdown_bit = 3;
   localparam int fault_tmr_bit = 2;
   localparam int fault_drv_bit = 1;

   // Charger event bit positions, shared by the event flags and the first mask.
   localparam int ev_adc_bit = 7;
   localparam int ev_iac_bit = 6;
   localparam int ev_vac_bit = 5;
   localparam int ev_wd_bit = 3;
   localparam int ev_cv_bit = 1;
   localparam int ev_chg_bit = 0;

   // Writable bits of the first mask; bits 4 and 2 are reserved.
   localparam logic [7:0] masks_first_wmask = 8'hEB;
   localparam logic [7:0] masks_first_reset = 8'h00;
   localparam logic [7:0] fault_flags_wmask = 8'hFE;
   localparam logic [7:0] reg_reset_value = 8'h00;

   // Control register: bit 0 one-shot ADC mode, bit 7 register reset (self clearing).
   localparam int ctrl_oneshot_bit = 0;
   localparam int ctrl_regreset_bit = 7;

   // Interrupt status layout: bit 1 fault event, bit 0 charger event.
   localparam int irq_fault_bit = 1;
   localparam int irq_charger_bit = 0;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic input_undervoltage;
      logic input_overvoltage;
      logic battery_overcurrent;
      logic battery_overvoltage;
      logic thermal_shutdown;
      logic charge_timer_expired;
      logic gate_driver_supply_pin_fault;
   } fault_in_t;

   typedef struct packed {
      logic adc_done;
      logic input_current_regulation;
      logic input_voltage_regulation;
      logic host_watchdog_expired;
      logic cv_timer_expired;
      logic [2:0] charge_state;
   } event_in_t;

   typedef struct packed {
      logic [7:0] fault_flags;
      logic [7:0] event_flags;
      logic [7:0] masks_first;
      logic [6:0] fault_prev;
      logic [4:0] event_prev;
      logic [2:0] charge_prev;
      logic oneshot;
      logic [1:0] irq_status;
      logic [1:0] irq_enable;
      logic irq_pulse;
      logic [7:0] rdata;
   } irq_state_t;

endpackage : chg_irq_pkg

// ### tb/charger_front_model.sv
`timescale 1ns/1ps
// Stands in for the fault detectors and charger status logic; every level is registered once.
module charger_front_model
   import chg_irq_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Requested condition levels.
   input wire chg_irq_pkg::fault_in_t fault_cmd_i,
   input wire chg_irq_pkg::event_in_t event_cmd_i,
   // Levels seen by the block.
   output chg_irq_pkg::fault_in_t fault_o,
   output chg_irq_pkg::event_in_t event_o
);
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         fault_o <= '0;
         event_o <= '0;
      end
      else
      begin
         fault_o <= fault_cmd_i;
         event_o <= event_cmd_i;
      end
   end
endmodule : charger_front_model

// ### tb/charger_fault_flag_and_event_mask_tb.sv
`timescale 1ns/1ps
module charger_fault_flag_and_event_mask_tb;
   import chg_irq_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   reg_req_t req = '0;
   fault_in_t fc = '0, fl;
   event_in_t ec = '0, el;
   logic [7:0] rdata_o;
   logic int_pulse_o, irq_o, rd_d = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] fl_exp[6] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h02, 8'h01};
   int errors = 0, tests_run = 0;
   charger_front_model model_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .fault_cmd_i(fc),
      .event_cmd_i(ec), .fault_o(fl), .event_o(el));
   charger_fault_flag_and_event_mask dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
      .rdata_o(rdata_o), .fault_i(fl), .event_i(el), .int_pulse_o(int_pulse_o), .irq_o(irq_o));
   initial
   begin
      forever #4 clk_i = ~clk_i;
   end
   task conclude;
      if (errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude
   task cmp(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
      @(posedge clk_i);
      req <= '{a, d, w, r};
      @(posedge clk_i);
      req <= '0;
   endtask : op
   task rd(input logic [7:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      op(a, 8'h00, 1'b0, 1'b1);
   endtask : rd
   task stim(input fault_in_t f, input event_in_t e, input logic p);
      @(posedge clk_i);
      fc <= f;
      ec <= e;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      cmp({7'h00, int_pulse_o}, {7'h00, p});
   endtask : stim
   // Read data stands only in the cycle after the strobe.
   always @(negedge clk_i)
   begin
      if (rd_d)
         cmp(rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
      rd_d = req.rd;
   end
   initial
   begin
      #200us;
      errors++;
      conclude();
   end
   initial
   begin
      fault_in_t f;
      void'($urandom(32'h2397));
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(8'h28, 8'h00);
      rd(8'h27, 8'h00);
      for (int i = 0; i < 7; i++)
      begin
         f = 7'h40 >> i;
         stim(f, '0, 1'b1);
         rd(8'h27, {f, 1'b0});
         rd(8'h27, 8'h00);
         stim('0, '0, 1'b0);
      end
      f = 7'($urandom);
      stim(f, '0, f != 0);
      rd(8'h27, {f, 1'b0});
      stim('0, '0, 1'b0);
      op(8'h32, 8'h01, 1'b1, 1'b0);
      op(8'h28, 8'hFF, 1'b1, 1'b0);
      rd(8'h28, 8'hEB);
      for (int m = 0; m < 2; m++)
         for (int j = 0; j < 6; j++)
         begin
            stim('0, j < 5 ? 8'h80 >> j : 8'h01, m == 1);
            rd(8'h25, fl_exp[j]);
            stim('0, '0, j == 5 && m == 1);
            rd(8'h25, j == 5 ? 8'h01 : 8'h00);
            if (j == 5)
               op(8'h28, 8'h00, 1'b1, 1'b0);
         end
      op(8'h32, 8'h00, 1'b1, 1'b0);
      stim('0, 8'h80, 1'b0);
      rd(8'h25, 8'h00);
      stim('0, '0, 1'b0);
      op(8'h30, 8'h03, 1'b1, 1'b0);
      op(8'h31, 8'h03, 1'b1, 1'b0);
      stim(7'h01, '0, 1'b1);
      cmp({7'h00, irq_o}, 8'h01);
      op(8'h31, 8'h00, 1'b1, 1'b0);
      @(negedge clk_i);
      cmp({7'h00, irq_o}, 8'h00);
      op(8'h31, 8'h03, 1'b1, 1'b0);
      @(negedge clk_i);
      cmp({7'h00, irq_o}, 8'h01);
      op(8'h30, 8'h03, 1'b1, 1'b0);
      @(negedge clk_i);
      cmp({7'h00, irq_o}, 8'h00);
      rd(8'h27, 8'h02);
      op(8'h7F, 8'hFF, 1'b1, 1'b0);
      rd(8'h7F, 8'h00);
      @(posedge clk_i);
      req <= '{8'h28, 8'hA5, 1'b1, 1'b0};
      exp_q.push_back(8'hA1);
      @(posedge clk_i);
      req <= '{8'h28, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      req <= '0;
      op(8'h28, 8'hFF, 1'b1, 1'b0);
      op(8'h32, 8'h80, 1'b1, 1'b0);
      rd(8'h28, 8'h00);
      rd(8'h31, 8'h00);
      repeat (3) @(posedge clk_i);
      conclude();
   end
endmodule : charger_fault_flag_and_event_mask_tb
